// >>> core/tsr_device.sv
// Sensor end: result register and its two-wire read engine
//
// The implementer's own choice: the address-and-strobe port.
`timescale 1ns/1ps
`default_nettype none
`include "tsr_params.svh"
module tsr_device (
   input  wire logic        clk,
   input  wire logic        sys_rst,
   tsr_link_if.device       link,
   input  wire logic [11:0] convResult,
   input  wire logic        convDone,
   input  wire logic [1:0]  resolutionSelect,
   input  wire logic [2:0]  strappedAddressPins,
   input  wire logic        shutdownAtPowerUp,
   output logic             startupMeasure,
   output logic             readActive,
   output logic [15:0]      temperatureReading
);
   logic [1:0] sclSync;
   logic [1:0] sdaSync;
   logic       sclPrev;
   logic       sdaPrev;
   logic       sclS;
   logic       sdaS;
   logic       sclRise;
   logic       sclFall;
   logic       startSeen;
   logic       stopSeen;

   tsr_pkg::tsr_dev_state_t  state, next_state;
   tsr_pkg::tsr_byte_phase_t phase, next_phase;
   logic [3:0]  cnt, next_cnt;
   logic [7:0]  rxShift, next_rxShift;
   logic [7:0]  txShift, next_txShift;
   logic [7:0]  snapLow, next_snapLow;
   logic [7:0]  pointer, next_pointer;
   logic        sdaLow, next_sdaLow;
   logic        readMode, next_readMode;
   logic        lowNext, next_lowNext;
   logic        masterAck, next_masterAck;
   logic        byteAck, next_byteAck;
   logic        ackNow;
   logic        ptrValid;
   logic [15:0] readWord;

   logic [15:0] next_temperatureReading;
   logic [15:0] pendVal, next_pendVal;
   logic        pending, next_pending;
   logic        startDone, next_startDone;
   logic        next_startupMeasure;
   logic [15:0] resMask;
   logic [15:0] masked;

   // Link pins pass two flip-flops before use
   always_ff @(posedge clk or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         sclSync <= 2'h3;
         sdaSync <= 2'h3;
         sclPrev <= 1'b1;
         sdaPrev <= 1'b1;
      end
      else
      begin
         sclSync <= {sclSync[0], link.scl};
         sdaSync <= {sdaSync[0], link.sda};
         sclPrev <= sclSync[1];
         sdaPrev <= sdaSync[1];
      end
   end

   assign sclS      = sclSync[1];
   assign sdaS      = sdaSync[1];
   assign sclRise   = sclS & ~sclPrev;
   assign sclFall   = ~sclS & sclPrev;
   assign startSeen = sclS & sclPrev & sdaPrev & ~sdaS;
   assign stopSeen  = sclS & sclPrev & ~sdaPrev & sdaS;

   assign link.devSdaOut = 1'b0;
   assign link.devSdaOen = ~sdaLow;
   assign readActive     = (state == tsr_pkg::DEV_TX) || (state == tsr_pkg::DEV_ACKRX);

   // Registers other than the result read as zero here
   assign readWord = (pointer == `TSR_PTR_RESULT) ? temperatureReading : 16'h0000;

   always_comb
   begin
      case (rxShift)
         `TSR_PTR_RESULT, `TSR_PTR_CONFIG, `TSR_PTR_TLOW, `TSR_PTR_THIGH,
         `TSR_PTR_NVCONFIG, `TSR_PTR_NVTLOW, `TSR_PTR_NVTHIGH: ptrValid = 1'b1;
         default: ptrValid = 1'b0;
      endcase
   end

   always_comb
   begin
      next_state     = state;
      next_phase     = phase;
      next_cnt       = cnt;
      next_rxShift   = rxShift;
      next_txShift   = txShift;
      next_snapLow   = snapLow;
      next_pointer   = pointer;
      next_sdaLow    = sdaLow;
      next_readMode  = readMode;
      next_lowNext   = lowNext;
      next_masterAck = masterAck;
      next_byteAck   = byteAck;
      ackNow         = 1'b0;
      case (state)
         tsr_pkg::DEV_IDLE:
         begin
            next_sdaLow = 1'b0;
         end
         tsr_pkg::DEV_RX:
         begin
            if (sclRise)
            begin
               next_rxShift = {rxShift[6:0], sdaS};
               next_cnt     = cnt + 4'h1;
            end
            else if (sclFall && (cnt == `TSR_BITS_PER_BYTE))
            begin
               case (phase)
                  tsr_pkg::PH_ADDR:
                  begin
                     ackNow        = (rxShift[7:1] == {`TSR_ADDR_FIXED, strappedAddressPins});
                     next_readMode = rxShift[0];
                  end
                  tsr_pkg::PH_PTR:
                  begin
                     ackNow = ptrValid;
                     if (ptrValid)
                        next_pointer = rxShift;
                  end
                  default:
                  begin
                     ackNow = (pointer != `TSR_PTR_RESULT);
                  end
               endcase
               next_byteAck = ackNow;
               next_sdaLow  = ackNow;
               next_cnt     = 4'h0;
               next_state   = tsr_pkg::DEV_ACKTX;
            end
         end
         tsr_pkg::DEV_ACKTX:
         begin
            if (sclFall)
            begin
               next_sdaLow = 1'b0;
               next_cnt    = 4'h0;
               if (!byteAck)
                  next_state = tsr_pkg::DEV_IDLE;
               else if ((phase == tsr_pkg::PH_ADDR) && readMode)
               begin
                  next_txShift = readWord[15:8];
                  next_snapLow = readWord[7:0];
                  next_sdaLow  = ~readWord[15];
                  next_lowNext = 1'b1;
                  next_state   = tsr_pkg::DEV_TX;
               end
               else
               begin
                  next_phase = (phase == tsr_pkg::PH_ADDR) ? tsr_pkg::PH_PTR : tsr_pkg::PH_DATA;
                  next_state = tsr_pkg::DEV_RX;
               end
            end
         end
         tsr_pkg::DEV_TX:
         begin
            if (sclFall)
            begin
               next_cnt = cnt + 4'h1;
               if (cnt == `TSR_BITS_PER_BYTE - 4'h1)
               begin
                  next_sdaLow = 1'b0;
                  next_state  = tsr_pkg::DEV_ACKRX;
               end
               else
               begin
                  next_txShift = {txShift[6:0], 1'b0};
                  next_sdaLow  = ~txShift[6];
               end
            end
         end
         tsr_pkg::DEV_ACKRX:
         begin
            if (sclRise)
               next_masterAck = ~sdaS;
            else if (sclFall)
            begin
               next_cnt = 4'h0;
               if (!masterAck)
                  next_state = tsr_pkg::DEV_IDLE;
               else if (lowNext)
               begin
                  next_txShift = snapLow;
                  next_sdaLow  = ~snapLow[7];
                  next_lowNext = 1'b0;
                  next_state   = tsr_pkg::DEV_TX;
               end
               else
               begin
                  next_txShift = readWord[15:8];
                  next_snapLow = readWord[7:0];
                  next_sdaLow  = ~readWord[15];
                  next_lowNext = 1'b1;
                  next_state   = tsr_pkg::DEV_TX;
               end
            end
         end
         default:
         begin
            next_state = tsr_pkg::DEV_IDLE;
         end
      endcase
      if (stopSeen)
      begin
         next_state  = tsr_pkg::DEV_IDLE;
         next_sdaLow = 1'b0;
      end
      else if (startSeen)
      begin
         next_state  = tsr_pkg::DEV_RX;
         next_phase  = tsr_pkg::PH_ADDR;
         next_cnt    = 4'h0;
         next_sdaLow = 1'b0;
      end
   end

   always_ff @(posedge clk or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         state     <= tsr_pkg::DEV_IDLE;
         phase     <= tsr_pkg::PH_ADDR;
         cnt       <= 4'h0;
         rxShift   <= 8'h00;
         txShift   <= 8'h00;
         snapLow   <= 8'h00;
         pointer   <= `TSR_PTR_RESULT;
         sdaLow    <= 1'b0;
         readMode  <= 1'b0;
         lowNext   <= 1'b0;
         masterAck <= 1'b0;
         byteAck   <= 1'b0;
      end
      else
      begin
         state     <= next_state;
         phase     <= next_phase;
         cnt       <= next_cnt;
         rxShift   <= next_rxShift;
         txShift   <= next_txShift;
         snapLow   <= next_snapLow;
         pointer   <= next_pointer;
         sdaLow    <= next_sdaLow;
         readMode  <= next_readMode;
         lowNext   <= next_lowNext;
         masterAck <= next_masterAck;
         byteAck   <= next_byteAck;
      end
   end

   // Resolution mask keeps bits below the data field at zero
   always_comb
   begin
      case (resolutionSelect)
         `TSR_RES_9:  resMask = `TSR_MASK_9;
         `TSR_RES_10: resMask = `TSR_MASK_10;
         `TSR_RES_11: resMask = `TSR_MASK_11;
         default:     resMask = `TSR_MASK_12;
      endcase
   end

   // Sign lands in bit 15, lowest 12-bit count in bit 4
   assign masked = {convResult, 4'h0} & resMask;

   always_comb
   begin
      next_temperatureReading = temperatureReading;
      next_pendVal            = pendVal;
      next_pending            = pending;
      next_startDone          = 1'b1;
      next_startupMeasure     = ~startDone & shutdownAtPowerUp;
      if (!readActive && pending)
      begin
         next_temperatureReading = pendVal;
         next_pending            = 1'b0;
      end
      if (convDone)
      begin
         if (readActive)
         begin
            next_pendVal = masked;
            next_pending = 1'b1;
         end
         else
         begin
            next_temperatureReading = masked;
            next_pending            = 1'b0;
         end
      end
   end

   always_ff @(posedge clk or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         temperatureReading <= `TSR_RESULT_RESET;
         pendVal            <= `TSR_RESULT_RESET;
         pending            <= 1'b0;
         startDone          <= 1'b0;
         startupMeasure     <= 1'b0;
      end
      else
      begin
         temperatureReading <= next_temperatureReading;
         pendVal            <= next_pendVal;
         pending            <= next_pending;
         startDone          <= next_startDone;
         startupMeasure     <= next_startupMeasure;
      end
   end
endmodule
`default_nettype wire

// >>> core/tsr_host.sv
// Host end: two-wire master that reads the result word
`timescale 1ns/1ps
`default_nettype none
`include "tsr_params.svh"
module tsr_host (
   input  wire logic        clk,
   input  wire logic        sys_rst,
   tsr_link_if.host         link,
   input  wire logic [1:0]  regAddr,
   input  wire logic [15:0] regWdata,
   input  wire logic        regWr,
   input  wire logic        regRd,
   output logic [15:0]      regRdata
);
   localparam logic [3:0] QUARTER = 4'(`TSR_QUARTER);

   logic [1:0] sdaSync;
   tsr_pkg::tsr_host_state_t state, next_state;
   logic [3:0]  divCnt, next_divCnt;
   logic [1:0]  ph, next_ph;
   logic [3:0]  bitIdx, next_bitIdx;
   logic [1:0]  byteIdx, next_byteIdx;
   logic [7:0]  rxShift, next_rxShift;
   logic        sclLow, next_sclLow;
   logic        sdaRel, next_sdaRel;
   logic        nackSeen, next_nackSeen;
   logic        cmdWrite, next_cmdWrite;
   logic        cmdTwo, next_cmdTwo;
   logic        cmdWithData, next_cmdWithData;
   logic [2:0]  cmdPins, next_cmdPins;
   logic [7:0]  ptrByte, next_ptrByte;
   logic [7:0]  dataByte, next_dataByte;
   logic        busy, next_busy;
   logic        nackErr, next_nackErr;
   logic [15:0] result, next_result;
   logic [15:0] next_regRdata;
   logic        tick;
   logic        txByte;
   logic        lastByte;
   logic [7:0]  curByte;

   always_ff @(posedge clk or posedge sys_rst)
   begin
      if (sys_rst)
         sdaSync <= 2'h3;
      else
         sdaSync <= {sdaSync[0], link.sda};
   end

   assign link.hostSclOut = 1'b0;
   assign link.hostSclOen = ~sclLow;
   assign link.hostSdaOut = 1'b0;
   assign link.hostSdaOen = sdaRel;

   assign tick     = (divCnt == QUARTER - 4'h1);
   assign txByte   = cmdWrite || (byteIdx == 2'h0);
   // A two-byte read with the data bit set acks the lower byte and takes the upper byte again
   assign lastByte = cmdWrite ? (byteIdx == (cmdWithData ? 2'h2 : 2'h1))
                              : (byteIdx == (cmdTwo ? (cmdWithData ? 2'h3 : 2'h2) : 2'h1));
   assign curByte  = (byteIdx == 2'h0) ? {`TSR_ADDR_FIXED, cmdPins, ~cmdWrite}
                   : (byteIdx == 2'h1) ? ptrByte : dataByte;

   always_comb
   begin
      next_state       = state;
      next_divCnt      = tick ? 4'h0 : divCnt + 4'h1;
      next_ph          = tick ? ph + 2'h1 : ph;
      next_bitIdx      = bitIdx;
      next_byteIdx     = byteIdx;
      next_rxShift     = rxShift;
      next_sclLow      = sclLow;
      next_sdaRel      = sdaRel;
      next_nackSeen    = nackSeen;
      next_cmdWrite    = cmdWrite;
      next_cmdTwo      = cmdTwo;
      next_cmdWithData = cmdWithData;
      next_cmdPins     = cmdPins;
      next_ptrByte     = ptrByte;
      next_dataByte    = dataByte;
      next_busy        = busy;
      next_nackErr     = nackErr;
      next_result      = result;
      case (state)
         tsr_pkg::HOST_IDLE:
         begin
            next_sclLow = 1'b0;
            next_sdaRel = 1'b1;
            if (regWr && (regAddr == `TSR_REG_CMD))
            begin
               next_cmdWrite    = regWdata[0];
               next_cmdTwo      = regWdata[1];
               next_cmdWithData = regWdata[2];
               next_cmdPins     = regWdata[5:3];
               next_busy        = 1'b1;
               next_nackErr     = 1'b0;
               next_byteIdx     = 2'h0;
               next_bitIdx      = 4'h0;
               next_divCnt      = 4'h0;
               next_ph          = 2'h0;
               next_state       = tsr_pkg::HOST_START;
            end
            else if (regWr && (regAddr == `TSR_REG_BYTES))
            begin
               next_ptrByte  = regWdata[7:0];
               next_dataByte = regWdata[15:8];
            end
         end
         tsr_pkg::HOST_START:
         begin
            if (tick && (ph == 2'h0))
               next_sdaRel = 1'b0;
            else if (tick && (ph == 2'h1))
            begin
               next_sclLow = 1'b1;
               next_ph     = 2'h0;
               next_state  = tsr_pkg::HOST_XFER;
            end
         end
         tsr_pkg::HOST_XFER:
         begin
            if (tick)
            begin
               case (ph)
                  2'h0:
                  begin
                     if (bitIdx != `TSR_BITS_PER_BYTE)
                        next_sdaRel = txByte ? curByte[3'(4'h7 - bitIdx)] : 1'b1;
                     else
                        next_sdaRel = txByte | lastByte;
                  end
                  2'h1:
                  begin
                     next_sclLow = 1'b0;
                  end
                  2'h2:
                  begin
                     if (bitIdx != `TSR_BITS_PER_BYTE)
                        next_rxShift = {rxShift[6:0], sdaSync[1]};
                     else
                        next_nackSeen = txByte & sdaSync[1];
                  end
                  default:
                  begin
                     next_sclLow = 1'b1;
                     next_bitIdx = bitIdx + 4'h1;
                     if (bitIdx == `TSR_BITS_PER_BYTE)
                     begin
                        next_bitIdx = 4'h0;
                        if (!txByte && (byteIdx == 2'h1))
                           next_result = {rxShift, 8'h00};
                        else if (!txByte)
                           next_result = {result[15:8], rxShift};
                        if (nackSeen || lastByte)
                        begin
                           next_nackErr = nackSeen;
                           next_state   = tsr_pkg::HOST_STOP;
                        end
                        else
                           next_byteIdx = byteIdx + 2'h1;
                     end
                  end
               endcase
            end
         end
         tsr_pkg::HOST_STOP:
         begin
            if (tick)
            begin
               case (ph)
                  2'h0: next_sdaRel = 1'b0;
                  2'h1: next_sclLow = 1'b0;
                  2'h2: next_sdaRel = 1'b1;
                  default:
                  begin
                     next_busy  = 1'b0;
                     next_state = tsr_pkg::HOST_IDLE;
                  end
               endcase
            end
         end
         default:
         begin
            next_state = tsr_pkg::HOST_IDLE;
         end
      endcase
      case (regAddr)
         `TSR_REG_CMD:    next_regRdata = {10'h000, cmdPins, cmdWithData, cmdTwo, cmdWrite};
         `TSR_REG_BYTES:  next_regRdata = {dataByte, ptrByte};
         `TSR_REG_STATUS: next_regRdata = {14'h0000, nackErr, busy};
         default:         next_regRdata = result;
      endcase
      if (!regRd)
         next_regRdata = 16'h0000;
   end

   always_ff @(posedge clk or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         state       <= tsr_pkg::HOST_IDLE;
         divCnt      <= 4'h0;
         ph          <= 2'h0;
         bitIdx      <= 4'h0;
         byteIdx     <= 2'h0;
         rxShift     <= 8'h00;
         sclLow      <= 1'b0;
         sdaRel      <= 1'b1;
         nackSeen    <= 1'b0;
         cmdWrite    <= 1'b0;
         cmdTwo      <= 1'b0;
         cmdWithData <= 1'b0;
         cmdPins     <= 3'h0;
         ptrByte     <= `TSR_PTR_RESULT;
         dataByte    <= 8'h00;
         busy        <= 1'b0;
         nackErr     <= 1'b0;
         result      <= 16'h0000;
         regRdata    <= 16'h0000;
      end
      else
      begin
         state       <= next_state;
         divCnt      <= next_divCnt;
         ph          <= next_ph;
         bitIdx      <= next_bitIdx;
         byteIdx     <= next_byteIdx;
         rxShift     <= next_rxShift;
         sclLow      <= next_sclLow;
         sdaRel      <= next_sdaRel;
         nackSeen    <= next_nackSeen;
         cmdWrite    <= next_cmdWrite;
         cmdTwo      <= next_cmdTwo;
         cmdWithData <= next_cmdWithData;
         cmdPins     <= next_cmdPins;
         ptrByte     <= next_ptrByte;
         dataByte    <= next_dataByte;
         busy        <= next_busy;
         nackErr     <= next_nackErr;
         result      <= next_result;
         regRdata    <= next_regRdata;
      end
   end
endmodule
`default_nettype wire

// >>> core/tsr_link_if.sv
// Two-wire link joining the host controller and the sensor device
`timescale 1ns/1ps
`default_nettype none
interface tsr_link_if;
   logic hostSclOut;
   logic hostSclOen;
   logic hostSdaOut;
   logic hostSdaOen;
   logic devSdaOut;
   logic devSdaOen;
   logic scl;
   logic sda;
   // Open-drain wired AND, released lines pull high
   assign scl = hostSclOen | hostSclOut;
   assign sda = (hostSdaOen | hostSdaOut) & (devSdaOen | devSdaOut);
   modport host (output hostSclOut, output hostSclOen, output hostSdaOut, output hostSdaOen, input sda);
   modport device (output devSdaOut, output devSdaOen, input scl, input sda);
endinterface
`default_nettype wire

// >>> core/tsr_params.svh
// Constants for the temperature reading link, both ends
`ifndef TSR_PARAMS_SVH
`define TSR_PARAMS_SVH
`define TSR_ADDR_FIXED   4'h9
`define TSR_PTR_RESULT   8'h00
`define TSR_PTR_CONFIG   8'h01
`define TSR_PTR_TLOW     8'h02
`define TSR_PTR_THIGH    8'h03
`define TSR_PTR_NVCONFIG 8'h11
`define TSR_PTR_NVTLOW   8'h12
`define TSR_PTR_NVTHIGH  8'h13
`define TSR_RESULT_RESET 16'h0000
`define TSR_RES_9        2'h0
`define TSR_RES_10       2'h1
`define TSR_RES_11       2'h2
`define TSR_MASK_9       16'hFF80
`define TSR_MASK_10      16'hFFC0
`define TSR_MASK_11      16'hFFE0
`define TSR_MASK_12      16'hFFF0
`define TSR_BITS_PER_BYTE 4'h8
`define TSR_CLK_NS       10
`define TSR_SCL_PERIOD_NS 80
`define TSR_QUARTER      (`TSR_SCL_PERIOD_NS / (4 * `TSR_CLK_NS))
`define TSR_REG_CMD      2'h0
`define TSR_REG_BYTES    2'h1
`define TSR_REG_STATUS   2'h2
`define TSR_REG_RESULT   2'h3
`endif

// >>> core/tsr_pkg.sv
// Types shared by both ends of the temperature reading link
package tsr_pkg;
   typedef enum logic [2:0] {DEV_IDLE, DEV_RX, DEV_ACKTX, DEV_TX, DEV_ACKRX} tsr_dev_state_t;
   typedef enum logic [1:0] {PH_ADDR, PH_PTR, PH_DATA} tsr_byte_phase_t;
   typedef enum logic [1:0] {HOST_IDLE, HOST_START, HOST_XFER, HOST_STOP} tsr_host_state_t;
endpackage

// >>> verif/testbench.sv
// Self-checking bench for host and device joined by the link
`timescale 1ns/1ps
`default_nettype none
module testbench;
   logic        clk;
   logic        sys_rst;
   logic [1:0]  regAddr;
   logic [15:0] regWdata;
   logic        regWr;
   logic        regRd;
   logic [15:0] regRdata;
   logic [11:0] convResult;
   logic        convDone;
   logic [1:0]  resolutionSelect;
   logic        shutdownAtPowerUp;
   logic        startupMeasure;
   logic        readActive;
   logic [15:0] temperatureReading;
   logic [15:0] got;
   int          err_total;
   int          checked;
   int          pulses;
   int          n;
   tsr_link_if link ();
   tsr_host tsr_host_inst (.clk(clk), .sys_rst(sys_rst), .link(link), .regAddr(regAddr),
      .regWdata(regWdata), .regWr(regWr), .regRd(regRd), .regRdata(regRdata));
   tsr_device tsr_device_inst (.clk(clk), .sys_rst(sys_rst), .link(link), .convResult(convResult),
      .convDone(convDone), .resolutionSelect(resolutionSelect), .strappedAddressPins(3'h1),
      .shutdownAtPowerUp(shutdownAtPowerUp), .startupMeasure(startupMeasure), .readActive(readActive),
      .temperatureReading(temperatureReading));
   tsr_link_checker tsr_link_checker_inst (.clk(clk), .sys_rst(sys_rst), .hostSclOut(link.hostSclOut),
      .hostSclOen(link.hostSclOen), .hostSdaOut(link.hostSdaOut), .hostSdaOen(link.hostSdaOen),
      .devSdaOut(link.devSdaOut), .devSdaOen(link.devSdaOen), .scl(link.scl), .sda(link.sda));
   task automatic chk(input logic [15:0] act, input logic [15:0] exp);
      checked++;
      if (act !== exp)
      begin
         err_total++;
         $display("Error at %0t: got %h expected %h", $time, act, exp);
      end
   endtask
   task automatic wr(input logic [1:0] a, input logic [15:0] d);
      @(posedge clk);
      regWr    <= 1'b1;
      regAddr  <= a;
      regWdata <= d;
      @(posedge clk);
      regWr <= 1'b0;
   endtask
   task automatic rd(input logic [1:0] a, output logic [15:0] d);
      @(posedge clk);
      regRd   <= 1'b1;
      regAddr <= a;
      @(posedge clk);
      regRd <= 1'b0;
      #1 d = regRdata;
   endtask
   task automatic xfer(input logic [15:0] cmd, output logic [15:0] st);
      if (cmd !== 16'h0000)
         wr(2'h0, cmd);
      st = 16'h0001;
      for (int i = 0; i < 2000 && st[0] !== 1'b0; i++)
         rd(2'h2, st);
      if (st[0] !== 1'b0)
         err_total++;
   endtask
   task automatic conv(input logic [11:0] v, input logic [1:0] res);
      @(posedge clk);
      convDone         <= 1'b1;
      convResult       <= v;
      resolutionSelect <= res;
      @(posedge clk);
      convDone <= 1'b0;
      @(posedge clk);
      #1;
   endtask
   task automatic final_report;
      $display("Comparisons %0d, errors %0d", checked, err_total);
      if (err_total == 0 && checked > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask
   always @(posedge clk)
      if (startupMeasure === 1'b1)
         pulses++;
   initial
   begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   initial
   begin
      #300000;
      err_total++;
      final_report();
   end
   initial
   begin
      {sys_rst, regWr, regRd, convDone} = 4'h8;
      shutdownAtPowerUp = 1'b1;
      {regAddr, regWdata, convResult, resolutionSelect} = '0;
      {err_total, checked, pulses} = '0;
      repeat (3) @(posedge clk);
      sys_rst <= 1'b0;
      repeat (4) @(posedge clk);
      chk(16'(pulses), 16'h0001);
      chk(temperatureReading, 16'h0000);
      xfer(16'h000A, got);
      chk(got & 16'h0002, 16'h0000);
      rd(2'h3, got);
      chk(got, 16'h0000);
      for (int r = 0; r < 4; r++)
      begin
         conv(12'hF5E, 2'(r));
         chk(temperatureReading, 16'hF5E0 & (16'hFFFF << (7 - r)));
         xfer(16'h000A, got);
         rd(2'h3, got);
         chk(got, 16'hF5E0 & (16'hFFFF << (7 - r)));
      end
      conv(12'h7D0, 2'h3);
      chk(temperatureReading, 16'(125 * 256));
      xfer(16'h0008, got);
      rd(2'h3, got);
      chk(got, 16'h7D00);
      xfer(16'h000E, got);
      rd(2'h3, got);
      chk(got, 16'h7D7D);
      xfer(16'h0012, got);
      chk(got & 16'h0002, 16'h0002);
      wr(2'h1, 16'h5500);
      xfer(16'h000D, got);
      chk(got & 16'h0002, 16'h0002);
      chk(temperatureReading, 16'h7D00);
      wr(2'h0, 16'h000A);
      for (n = 0; n < 500 && readActive !== 1'b1; n++)
         @(posedge clk);
      if (n == 500)
         err_total++;
      conv(12'h190, 2'h3);
      chk(temperatureReading, 16'h7D00);
      xfer(16'h0000, got);
      rd(2'h3, got);
      chk(got, 16'h7D00);
      chk(temperatureReading, 16'h1900);
      // Second reset without the power-up measurement option
      @(posedge clk);
      shutdownAtPowerUp <= 1'b0;
      sys_rst           <= 1'b1;
      repeat (3) @(posedge clk);
      sys_rst <= 1'b0;
      repeat (4) @(posedge clk);
      chk(16'(pulses), 16'h0001);
      chk(temperatureReading, 16'h0000);
      xfer(16'h000A, got);
      rd(2'h3, got);
      chk(got, 16'h0000);
      final_report();
   end
endmodule
`default_nettype wire

// >>> verif/tsr_link_checker.sv
// Assertions on the two-wire link between host and device
`timescale 1ns/1ps
`default_nettype none
module tsr_link_checker (
   input wire logic clk,
   input wire logic sys_rst,
   input wire logic hostSclOut,
   input wire logic hostSclOen,
   input wire logic hostSdaOut,
   input wire logic hostSdaOen,
   input wire logic devSdaOut,
   input wire logic devSdaOen,
   input wire logic scl,
   input wire logic sda
);
   default clocking @(posedge clk); endclocking
   default disable iff (sys_rst);
   AST_DEV_DRIVES_LOW_ONLY: assert property (devSdaOut == 1'b0)
      else $error("Device data value not low");
   AST_HOST_DRIVES_LOW_ONLY: assert property (!hostSclOut && !hostSdaOut)
      else $error("Host line value not low");
   AST_RESET_RELEASES: assert property (disable iff (1'b0) sys_rst |-> devSdaOen && hostSdaOen && hostSclOen)
      else $error("Line driven during reset");
   AST_DEV_SDA_STILL_SCL_HIGH: assert property (scl && $past(scl) |-> $stable(devSdaOen))
      else $error("Device data changed while clock high");
   AST_DEV_LOW_BOUNDED: assert property ($fell(devSdaOen) |-> ##[1:120] devSdaOen)
      else $error("Device holds data line too long");
   AST_SCL_LOW_MIN: assert property ($fell(hostSclOen) |-> !hostSclOen [*2])
      else $error("Clock low phase too short");
   AST_SCL_HIGH_MIN: assert property ($rose(hostSclOen) |-> hostSclOen [*2])
      else $error("Clock high phase too short");
   AST_START_THEN_CLOCK: assert property ($fell(sda) && scl |-> ##[1:8] !scl)
      else $error("No clock after start");
   cover property ($fell(devSdaOen));
   cover property ($fell(sda) && scl);
   cover property ($rose(sda) && scl);
endmodule
`default_nettype wire
